/* File: dv/adcsc_conv_model.sv */
// converter core model: answers each channel after a settle time
// assumes conv_start_i stays high for the whole conversion
`timescale 1ns/100ps
`default_nettype none
module adcsc_conv_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       conv_start_i,
   input  wire logic [1:0] conv_ch_i,
   input  wire logic       slow_i,
   output logic            conv_done_o,
   output logic      [9:0] conv_data_o
);
   logic [7:0] wait_q;
   logic [7:0] cnt_q;
   logic [9:0] last_q;
   ////////////////////////////////////////////////////////////////////////////////
   // code carries channel and a running count, so misplaced results show
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wait_q      <= 8'h00;
         cnt_q       <= 8'h00;
         last_q      <= 10'h000;
         conv_done_o <= 1'b0;
         conv_data_o <= 10'h3ff;
      end else begin
         conv_done_o <= 1'b0;
         conv_data_o <= ~last_q; // released bus never shows the old code
         if (!conv_start_i || conv_done_o) begin
            wait_q <= 8'h00;
         end else if (wait_q >= (slow_i ? 8'd82 : 8'd52)) begin
            conv_done_o <= 1'b1;
            conv_data_o <= {conv_ch_i, cnt_q};
            last_q      <= {conv_ch_i, cnt_q};
            cnt_q       <= cnt_q + 8'h01;
         end else begin
            wait_q <= wait_q + 8'h01;
         end
      end
   end
endmodule : adcsc_conv_model
`default_nettype wire

/* File: dv/testbench.sv */
// bench: register bus master, round collection and flag handling
// assumes the converter model on the far side of the design
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        slow = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] rdata_o;
   logic [31:0] d;
   logic [1:0]  ch;
   logic        st, dn, eirq, irq;
   logic [9:0]  cd;
   int          mismatches = 0;
   int          total_checks = 0;
   int          i;
   always #20 clk_i = ~clk_i;
   adcsc_top adcsc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_ch_o(ch),
      .conv_start_o(st), .conv_done_i(dn), .conv_data_i(cd),
      .conversion_end_irq_o(eirq), .irq_o(irq));
   adcsc_conv_model adcsc_conv_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .conv_start_i(st), .conv_ch_i(ch), .slow_i(slow), .conv_done_o(dn), .conv_data_o(cd));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and compare helpers
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // bus cycles end at the falling edge so checks see settled outputs
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(negedge clk_i);
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask : rd
   function logic [31:0] res(input int k, input int n);
      return {16'h0, n[1:0], k[7:0], 6'h00};
   endfunction : res
   // wait for round end, acknowledge it, collect the four results
   task round(input int k);
      for (i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1);
      wr(8'h18, 32'h1);
      for (int n = 0; n < 4; n++) begin
         rd(8'(8'h08 + 4 * n));
         chk(d, res(k + n, n));
      end
      slow <= 1'($urandom % 2);
   endtask : round
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      d = $urandom(32'hefb2);
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(8'h00);
      chk(d, 32'h0);
      rd(8'h1c);
      chk(d, 32'h0);
      wr(8'h20, $urandom);
      rd(8'h20);
      chk(d, 32'h0);
      wr(8'h1c, 32'h1);
      wr(8'h00, 32'h4000);
      wr(8'h04, 32'h1);
      round(0);
      rd(8'h04);
      chk(d, 32'h0);
      chk({31'h0, eirq}, 32'h1);
      rd(8'h00);
      wr(8'h00, 32'h4008);
      chk({31'h0, eirq}, 32'h0);
      wr(8'h04, 32'h1);
      round(4);
      rd(8'h04);
      chk(d, 32'h1);
      wr(8'h00, 32'h4008);
      chk({31'h0, eirq}, 32'h1);
      round(8);
      rd(8'h00);
      chk({31'h0, d[15]}, 32'h1);
      wr(8'h00, 32'h4008);
      rd(8'h00);
      rd(8'h00);
      chk({31'h0, d[15]}, 32'h0);
      round(12);
      chk({31'h0, eirq}, 32'h1);
      wr(8'h04, 32'h0);
      for (i = 0; i < 300 && st !== 1'b0; i++) @(posedge clk_i);
      repeat (100) @(posedge clk_i);
      chk({31'h0, st}, 32'h0);
      // flag still set and unread: enable off hides it, a bare 0 write keeps it
      wr(8'h00, 32'h0008);
      chk({31'h0, eirq}, 32'h0);
      rd(8'h00);
      chk({31'h0, d[15]}, 32'h1);
      wr(8'h1c, 32'h0);
      rd(8'h18);
      chk(d, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(8'h1c, 32'h2);
      rd(8'h18);
      chk({31'h0, irq}, 32'h1);
      wr(8'h18, 32'h2);
      rd(8'h18);
      chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
      test_done();
   end
   // hang guard, well past four rounds of slow conversions
   initial begin
      #(40 * 20000);
      mismatches++;
      test_done();
   end
endmodule : testbench
`default_nettype wire

/* File: hdl/adcsc_result_mem.sv */
// four-word result store with registered read data
// assumes writes and reads on the same clock
`timescale 1ns/100ps
`default_nettype none
module adcsc_result_mem (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        wr_i,
   input  wire logic [1:0]  wr_idx_i,
   input  wire logic [9:0]  wr_data_i,
   input  wire logic [1:0]  rd_idx_i,
   output logic      [15:0] rd_data_o
);
   logic [9:0] mem_reg [0:3];

   // old round stays until overwritten by the new one
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 4; i++) mem_reg[i] <= 10'h000;
      end else if (wr_i) begin
         mem_reg[wr_idx_i] <= wr_data_i;
      end
   end

   // left-justified, six low bits always zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 16'h0000;
      end else begin
         rd_data_o <= {mem_reg[rd_idx_i], 6'h00};
      end
   end
endmodule : adcsc_result_mem
`default_nettype wire

/* File: hdl/adcsc_top.sv */
// four-channel continuous scan sequencer for one conversion unit
// assumes an external converter core that returns a 10-bit code when asked
`timescale 1ns/100ps
`default_nettype none
module adcsc_top (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   output logic      [1:0]  conv_ch_o,
   output logic             conv_start_o,
   input  wire logic        conv_done_i,
   input  wire logic [9:0]  conv_data_i,
   output logic             conversion_end_irq_o,
   output logic             irq_o
);
   ////////////////////////////////////////////////////////////////////
   adcsc_pkg::adcsc_state_t state_reg, state_next;
   logic [15:0] ctrl_reg;
   logic        conversion_run_bit;
   logic        flag_read_reg;        // flag seen as 1 by a read
   logic [1:0]  ch_reg;
   logic [$clog2(adcsc_pkg::CONV_CYCLES+1)-1:0] tmr_reg;
   logic [9:0]  sample_reg;
   logic [1:0]  irq_st_reg, irq_mask_reg;
   logic        rd_q_reg;
   logic [7:0]  rd_addr_reg;
   logic [15:0] res_rd;

   // address decode
   wire sel_cs    = addr_i == adcsc_pkg::OFS_CTRL_STATUS;
   wire sel_st    = addr_i == adcsc_pkg::OFS_START_CTRL;
   wire sel_ist   = addr_i == adcsc_pkg::OFS_IRQ_STATUS;
   wire sel_imk   = addr_i == adcsc_pkg::OFS_IRQ_MASK;
   wire wr_cs     = wr_i && sel_cs;
   wire wr_run    = wr_i && sel_st;
   wire cont_mode = ctrl_reg[adcsc_pkg::BIT_CONT_SCAN];
   wire conv_done = (state_reg == adcsc_pkg::ADCSC_CONV) && conv_done_i;
   wire ch_store  = state_reg == adcsc_pkg::ADCSC_STORE;
   wire round_end = ch_store && (ch_reg == 2'h3);
   // clear needs a prior read of 1; a completing round wins over the clear
   wire flag_clr  = wr_cs && !wdata_i[adcsc_pkg::BIT_END_FLAG] && flag_read_reg;
   wire end_flag  = ctrl_reg[adcsc_pkg::BIT_END_FLAG];
   // index from the live address: the store registers its word, so it must see
   // the strobe's address for the result to stand in the answer cycle
   wire [1:0] rd_idx = 2'(addr_i[4:2] - 3'h2);

   ////////////////////////////////////////////////////////////////////
   // sequencer: channel 0 first, then 1,2,3, then repeat or stop
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         adcsc_pkg::ADCSC_IDLE:  if (conversion_run_bit) state_next = adcsc_pkg::ADCSC_CONV;
         adcsc_pkg::ADCSC_CONV:  if (conv_done_i && tmr_reg == '0)
                                    state_next = adcsc_pkg::ADCSC_STORE;
         adcsc_pkg::ADCSC_STORE: begin
            if (!conversion_run_bit) state_next = adcsc_pkg::ADCSC_IDLE;   // stop by software
            else if (ch_reg != 2'h3 || cont_mode) state_next = adcsc_pkg::ADCSC_CONV;
            else state_next = adcsc_pkg::ADCSC_IDLE;
         end
         default: state_next = adcsc_pkg::ADCSC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) state_reg <= adcsc_pkg::ADCSC_IDLE;
      else state_reg <= state_next;
   end

   // channel counter and minimum conversion time
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ch_reg  <= 2'h0;
         tmr_reg <= '0;
      end else begin
         if (state_reg == adcsc_pkg::ADCSC_IDLE) ch_reg <= 2'h0;
         else if (ch_store) ch_reg <= ch_reg + 2'h1;
         if (state_reg != adcsc_pkg::ADCSC_CONV)
            tmr_reg <= ($bits(tmr_reg))'(adcsc_pkg::CONV_CYCLES - 1);
         else if (tmr_reg != '0) tmr_reg <= tmr_reg - 1'b1;
      end
   end

   // capture converter output while busy
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) sample_reg <= 10'h000;
      else if (conv_done) sample_reg <= conv_data_i;
   end

   assign conv_ch_o    = ch_reg;
   assign conv_start_o = state_reg == adcsc_pkg::ADCSC_CONV;

   adcsc_result_mem u_mem (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .wr_i      (ch_store),
      .wr_idx_i  (ch_reg),
      .wr_data_i (sample_reg),
      .rd_idx_i  (rd_idx),
      .rd_data_o (res_rd)
   );

   ////////////////////////////////////////////////////////////////////
   // control/status and run bit; hardware set beats software clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_reg           <= adcsc_pkg::CTRL_RESET;
         conversion_run_bit <= 1'b0;
         flag_read_reg      <= 1'b0;
      end else begin
         if (wr_cs) begin
            ctrl_reg[adcsc_pkg::BIT_IRQ_EN]    <= wdata_i[adcsc_pkg::BIT_IRQ_EN];
            ctrl_reg[adcsc_pkg::BIT_CONT_SCAN] <= wdata_i[adcsc_pkg::BIT_CONT_SCAN];
         end
         if (round_end) ctrl_reg[adcsc_pkg::BIT_END_FLAG] <= 1'b1;
         else if (flag_clr) ctrl_reg[adcsc_pkg::BIT_END_FLAG] <= 1'b0;
         if (round_end) flag_read_reg <= 1'b0;
         else if (rd_i && sel_cs && end_flag) flag_read_reg <= 1'b1;
         else if (flag_clr) flag_read_reg <= 1'b0;
         if (wr_run) conversion_run_bit <= wdata_i[adcsc_pkg::BIT_RUN];
         else if (round_end && !cont_mode) conversion_run_bit <= 1'b0;
      end
   end

   // sticky interrupt status: bit0 round end, bit1 conversion done; write 1 clears
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_st_reg   <= 2'h0;
         irq_mask_reg <= adcsc_pkg::IRQ_MASK_RESET;
      end else begin
         irq_st_reg <= (irq_st_reg & ~({2{wr_i && sel_ist}} & wdata_i[1:0]))
                       | {conv_done, round_end};
         if (wr_i && sel_imk) irq_mask_reg <= wdata_i[1:0];
      end
   end

   assign conversion_end_irq_o = end_flag && ctrl_reg[adcsc_pkg::BIT_IRQ_EN];
   assign irq_o              = |(irq_st_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////
   // read data one cycle after the strobe, only then
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_q_reg    <= 1'b0;
         rd_addr_reg <= 8'h00;
      end else begin
         rd_q_reg    <= rd_i;
         rd_addr_reg <= addr_i;
      end
   end

   wire is_res = rd_addr_reg >= adcsc_pkg::OFS_RESULT0 && rd_addr_reg < 8'h18
                 && rd_addr_reg[1:0] == 2'h0;
   logic [31:0] ctrl_rd;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) ctrl_rd <= 32'h0;
      else ctrl_rd <= {16'h0, ctrl_reg};
   end
   assign rdata_o = !rd_q_reg ? 32'h0 :
                    rd_addr_reg == adcsc_pkg::OFS_CTRL_STATUS ? ctrl_rd :
                    rd_addr_reg == adcsc_pkg::OFS_START_CTRL  ? {31'h0, conversion_run_bit} :
                    rd_addr_reg == adcsc_pkg::OFS_IRQ_STATUS  ? {30'h0, irq_st_reg} :
                    rd_addr_reg == adcsc_pkg::OFS_IRQ_MASK    ? {30'h0, irq_mask_reg} :
                    is_res ? {16'h0, res_rd} : 32'h0;

   ////////////////////////////////////////////////////////////////////
   a_flag_set_round: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      round_end |=> end_flag) else $error("end flag not set after round");
   a_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      end_flag && !flag_clr |=> end_flag) else $error("end flag dropped");
   a_clear_needs_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      end_flag && !flag_read_reg |=> end_flag) else $error("flag cleared unread");
   a_run_kept_cont: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      round_end && cont_mode && !wr_run |=> conversion_run_bit) else $error("run lost");
   a_run_cleared: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      round_end && !cont_mode && !wr_run |=> !conversion_run_bit) else $error("run kept");
   a_start_ch0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_reg == adcsc_pkg::ADCSC_IDLE && conversion_run_bit |=> conv_start_o && conv_ch_o == 2'h0)
      else $error("start not on channel 0");
   a_ch_advance: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ch_store && ch_reg != 2'h3 |=> ch_reg == $past(ch_reg) + 2'h1) else $error("bad channel");
   a_res_low_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      res_rd[5:0] == 6'h00) else $error("result low bits nonzero");
   a_irq_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      round_end && ctrl_reg[adcsc_pkg::BIT_IRQ_EN] && !wr_cs |=> conversion_end_irq_o)
      else $error("end interrupt missing");
endmodule : adcsc_top
`default_nettype wire

/* File: inc/adcsc_pkg.sv */
// package for the scan sequencer: register map, field layout, reset values, timing
// assumes nothing beyond a single 25 MHz clock domain
package adcsc_pkg;
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned CONV_TIME_NS  = 2000;   // per-channel conversion time
   localparam int unsigned CONV_CYCLES   = (CONV_TIME_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int unsigned NUM_CH        = 4;
   localparam int unsigned RES_W         = 10;
   localparam int unsigned RES_LSB       = 6;      // result sits in bits 15..6

   // register offsets (byte addresses, word aligned)
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFS_START_CTRL  = 8'h04;
   localparam logic [7:0] OFS_RESULT0     = 8'h08; // ch n at OFS_RESULT0 + 4n
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h1c;

   // control/status field positions
   localparam int unsigned BIT_END_FLAG   = 15;
   localparam int unsigned BIT_IRQ_EN     = 14;
   localparam int unsigned BIT_CONT_SCAN  = 3;
   localparam int unsigned BIT_RUN        = 0;     // in start control
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;

   typedef enum logic [1:0] {
      ADCSC_IDLE  = 2'b00,
      ADCSC_CONV  = 2'b01,
      ADCSC_STORE = 2'b11
   } adcsc_state_t;
endpackage : adcsc_pkg
